// ===== rtl/osc_trim_pkg.sv
package osc_trim_pkg;
    // register map, word aligned byte addresses
    localparam logic [7:0] SWITCH_BANK_A_OFFSET = 8'h00;
    localparam logic [7:0] SWITCH_BANK_B_OFFSET = 8'h04;
    localparam logic [7:0] TRIM_CTRL_OFFSET = 8'h08;
    localparam logic [7:0] TRIM_STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] GATE_STATUS_OFFSET = 8'h10;
    localparam logic [7:0] ERROR_INPUT_OFFSET = 8'h14;
    // bank a bit positions
    localparam int OFFSET_SIGN_BIT = 0;
    localparam int FORCE_ONES_BIT = 1;
    localparam int FORCE_ZEROS_BIT = 2;
    localparam int SHORT_GATE_BIT = 3;
    localparam int LAMP_TEST_BIT = 4;
    localparam int TEST_ENABLE_BIT = 5;
    localparam int AUTO_TUNE_BIT = 6;
    localparam int PHASE_CORR_BIT = 7;
    // bank b bit positions
    localparam int AUTO_RESET_BIT = 0;
    localparam int CHANNEL_LSB = 1;
    localparam int RATE_LSB = 5;
    // factory switch levels
    localparam logic [7:0] BANK_A_RESET = 8'h40;
    localparam logic [7:0] BANK_B_RESET = 8'hC0; // rate code 110 in b7..b5
    localparam logic [15:0] TRIM_RESET = 16'h8000;
    localparam logic [15:0] TRIM_STEP_RESET = 16'h0001;
    // gate times
    localparam int LONG_GATE_S = 1000;
    localparam int SHORT_GATE_S = 10;
    localparam int CLK_HZ = 100_000_000;
    localparam int SECOND_CYCLES = CLK_HZ;
    // rate codes and bit periods in clock cycles
    typedef enum logic [2:0] {
        RATE_SPARE_HI = 3'b111,
        RATE_300 = 3'b110,
        RATE_600 = 3'b101,
        RATE_1200 = 3'b100,
        RATE_2400 = 3'b011,
        RATE_4800 = 3'b010,
        RATE_9600 = 3'b001,
        RATE_SPARE_LO = 3'b000
    } rate_code_t;
    localparam int BAUD_300 = 300;
    localparam logic [31:0] BIT_CYCLES_300 = 32'(CLK_HZ / BAUD_300);
    localparam logic [31:0] BIT_CYCLES_600 = 32'(CLK_HZ / (BAUD_300 * 2));
    localparam logic [31:0] BIT_CYCLES_1200 = 32'(CLK_HZ / (BAUD_300 * 4));
    localparam logic [31:0] BIT_CYCLES_2400 = 32'(CLK_HZ / (BAUD_300 * 8));
    localparam logic [31:0] BIT_CYCLES_4800 = 32'(CLK_HZ / (BAUD_300 * 16));
    localparam logic [31:0] BIT_CYCLES_9600 = 32'(CLK_HZ / (BAUD_300 * 32));
    // character frame: start, seven data, mark, stop
    localparam int DATA_BITS = 7;
    localparam int FRAME_BITS = 10;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : osc_trim_pkg

// ===== rtl/rate_select.sv
`timescale 1ns/1ps
module rate_select
    import osc_trim_pkg::*;
(
    input wire logic [2:0] rate_code, // switch code, msb first
    output logic [31:0] bit_cycles, // clock cycles per serial bit
    output logic [15:0] baud // selected rate in baud
);
    // spare codes fall back to the slowest rate
    always_comb begin
        bit_cycles = BIT_CYCLES_300;
        baud = 16'(BAUD_300);
        unique case (rate_code)
            RATE_600: begin
                bit_cycles = BIT_CYCLES_600;
                baud = 16'(BAUD_300 * 2);
            end
            RATE_1200: begin
                bit_cycles = BIT_CYCLES_1200;
                baud = 16'(BAUD_300 * 4);
            end
            RATE_2400: begin
                bit_cycles = BIT_CYCLES_2400;
                baud = 16'(BAUD_300 * 8);
            end
            RATE_4800: begin
                bit_cycles = BIT_CYCLES_4800;
                baud = 16'(BAUD_300 * 16);
            end
            RATE_9600: begin
                bit_cycles = BIT_CYCLES_9600;
                baud = 16'(BAUD_300 * 32);
            end
            default: begin
                bit_cycles = BIT_CYCLES_300;
                baud = 16'(BAUD_300);
            end
        endcase
    end
endmodule : rate_select

// ===== rtl/oscillator_trim_strap_decode.sv
`timescale 1ns/1ps
module oscillator_trim_strap_decode
    import osc_trim_pkg::*;
#(
    parameter int TRIM_WIDTH = 16,
    parameter int ALARM_COUNT = 2,
    parameter int unsigned SECOND_LEN = SECOND_CYCLES
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] switch_bank_a, // first switch bank levels
    input wire logic [7:0] switch_bank_b, // second switch bank levels
    input wire logic [ALARM_COUNT-1:0] alarm_state, // real alarm levels
    input wire logic freq_error_valid, // pulse: frequency error ready
    input wire logic freq_error_high, // oscillator above target
    input wire logic time_error_valid, // pulse: time error ready
    input wire logic time_error_late, // oscillator losing time
    output logic [TRIM_WIDTH-1:0] trim_code, // trim converter code
    output logic [ALARM_COUNT-1:0] alarm_lamp, // alarm lamp drive
    output logic gate_active, // measurement gate open
    output logic gate_done, // pulse: gate closed
    output logic [31:0] bit_cycles, // serial bit period
    output logic offset_positive, // offset direction
    output logic [3:0] offset_channel, // offset channel, zero none
    output logic offset_enable, // offset applied
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    import osc_trim_pkg::*;

    // strap decode
    wire logic test_on = switch_bank_a[TEST_ENABLE_BIT];
    wire logic force_ones = test_on & switch_bank_a[FORCE_ONES_BIT];
    wire logic force_zeros = test_on & switch_bank_a[FORCE_ZEROS_BIT];
    wire logic short_gate = test_on & switch_bank_a[SHORT_GATE_BIT];
    wire logic lamp_test = test_on & switch_bank_a[LAMP_TEST_BIT];
    wire logic auto_tune = switch_bank_a[AUTO_TUNE_BIT];
    wire logic phase_corr = switch_bank_a[PHASE_CORR_BIT];
    wire logic [3:0] channel_sw = switch_bank_b[CHANNEL_LSB +: 4];
    wire logic [2:0] rate_sw = switch_bank_b[RATE_LSB +: 3];
    // any override holds the tuning loop still
    wire logic override_on = force_ones | force_zeros | short_gate
        | lamp_test;

    // software trim control
    logic [TRIM_WIDTH-1:0] trim_step;
    logic sw_hold;
    logic [TRIM_WIDTH-1:0] trim_acc;
    logic [31:0] sec_count;
    logic [9:0] gate_seconds;
    logic [31:0] gate_count;
    logic freq_seen;
    logic freq_high_seen;

    wire logic [9:0] gate_len = short_gate ? 10'(SHORT_GATE_S)
        : 10'(LONG_GATE_S);
    wire logic second_tick = sec_count == 32'(SECOND_LEN - 1);
    // a shorter gate picked mid-gate ends at the next second, no wrap
    wire logic gate_end = second_tick && gate_seconds >= gate_len - 10'd1;
    wire logic tune_ok = auto_tune && !override_on && !sw_hold;
    wire logic slew_ok = phase_corr && !override_on && !sw_hold;
    wire logic at_top = trim_acc > {TRIM_WIDTH{1'b1}} - trim_step;
    wire logic at_bottom = trim_acc < trim_step;
    // higher code lowers oscillator frequency
    wire logic step_up = (tune_ok && gate_end && freq_seen
        && freq_high_seen) || (slew_ok && time_error_valid
        && !time_error_late);
    wire logic step_down = (tune_ok && gate_end && freq_seen
        && !freq_high_seen) || (slew_ok && time_error_valid
        && time_error_late);
    wire logic [TRIM_WIDTH-1:0] next_trim = (step_up && !step_down
        && !at_top) ? trim_acc + trim_step : (step_down && !step_up
        && !at_bottom) ? trim_acc - trim_step : trim_acc;

    // one-second enable divider
    always_ff @(posedge aclk) begin
        if (!aresetn || second_tick) begin
            sec_count <= '0;
        end else begin
            sec_count <= sec_count + 32'd1;
        end
    end

    // gate seconds counter, restarts on each gate end
    always_ff @(posedge aclk) begin
        if (!aresetn || gate_end) begin
            gate_seconds <= '0;
        end else if (second_tick) begin
            gate_seconds <= gate_seconds + 10'd1;
        end
    end

    // latest frequency error seen during the gate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_seen <= 1'b0;
            freq_high_seen <= 1'b0;
        end else if (freq_error_valid) begin
            // set wins over the gate-end clear, sample kept for next gate
            freq_seen <= 1'b1;
            freq_high_seen <= freq_error_high;
        end else if (gate_end) begin
            freq_seen <= 1'b0;
            freq_high_seen <= 1'b0;
        end
    end

    // trim accumulator, frozen while overrides act
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_acc <= TRIM_WIDTH'(TRIM_RESET);
        end else begin
            trim_acc <= next_trim;
        end
    end

    // force ones has priority over force zeros
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_code <= TRIM_WIDTH'(TRIM_RESET);
        end else if (force_ones) begin
            trim_code <= {TRIM_WIDTH{1'b1}};
        end else if (force_zeros) begin
            trim_code <= '0;
        end else begin
            trim_code <= trim_acc;
        end
    end

    // lamps and gate status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_lamp <= '0;
            gate_done <= 1'b0;
        end else begin
            alarm_lamp <= lamp_test ? '1 : alarm_state;
            gate_done <= gate_end;
        end
    end
    assign gate_active = aresetn;

    // rate decode; the serial engine frames start, 7 data, mark, stop
    logic [31:0] rate_cycles;
    rate_select u_rate (
        .rate_code(rate_sw),
        .bit_cycles(rate_cycles),
        .baud()
    );

    // offset and rate outputs registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_cycles <= BIT_CYCLES_300;
            offset_positive <= 1'b0;
            offset_channel <= '0;
            offset_enable <= 1'b0;
        end else begin
            bit_cycles <= rate_cycles;
            offset_positive <= switch_bank_a[OFFSET_SIGN_BIT];
            offset_channel <= channel_sw;
            offset_enable <= |channel_sw;
        end
    end

    // axi4-lite write path: address and data taken in either order
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic wr_go = aw_held && w_held && !s_axi_bvalid;
    wire logic wr_step = aw_addr == TRIM_CTRL_OFFSET;
    wire logic wr_known = wr_step || aw_addr == TRIM_STATUS_OFFSET
        || aw_addr == SWITCH_BANK_A_OFFSET
        || aw_addr == SWITCH_BANK_B_OFFSET
        || aw_addr == GATE_STATUS_OFFSET
        || aw_addr == ERROR_INPUT_OFFSET;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    // control register: step size low half, hold in bit 16
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_step <= TRIM_WIDTH'(TRIM_STEP_RESET);
            sw_hold <= 1'b0;
        end else if (wr_go && wr_step) begin
            if (w_strb[0]) begin
                trim_step[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                trim_step[TRIM_WIDTH-1:8] <= w_data[TRIM_WIDTH-1:8];
            end
            if (w_strb[2]) begin
                sw_hold <= w_data[16];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read path, one cycle after the address is taken
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            SWITCH_BANK_A_OFFSET: rd_word = {24'h000000, switch_bank_a};
            SWITCH_BANK_B_OFFSET: rd_word = {24'h000000, switch_bank_b};
            TRIM_CTRL_OFFSET: rd_word = {15'h0000, sw_hold,
                16'(trim_step)};
            TRIM_STATUS_OFFSET: rd_word = {12'h000, override_on,
                force_zeros, force_ones, tune_ok, 16'(trim_code)};
            GATE_STATUS_OFFSET: rd_word = {21'h0, short_gate,
                gate_seconds};
            ERROR_INPUT_OFFSET: rd_word = {30'h0,
                freq_high_seen, freq_seen};
            default: rd_hit = 1'b0;
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : oscillator_trim_strap_decode

// ===== verif/trim_monitor.sv
`timescale 1ns/1ps
module trim_monitor
    import osc_trim_pkg::*;
#(
    parameter int TRIM_WIDTH = 16,
    parameter int ALARM_COUNT = 2,
    parameter int unsigned SECOND_LEN = 10
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset
    input wire logic [7:0] switch_bank_a, // bank a
    input wire logic [7:0] switch_bank_b, // bank b
    input wire logic [ALARM_COUNT-1:0] alarm_state, // real alarms
    input wire logic [TRIM_WIDTH-1:0] trim_code, // trim code
    input wire logic [ALARM_COUNT-1:0] alarm_lamp, // lamps
    input wire logic gate_done, // gate end pulse
    input wire logic [31:0] bit_cycles, // bit period
    input wire logic offset_positive, // offset sign
    input wire logic [3:0] offset_channel, // offset channel
    input wire logic offset_enable // offset on
);
    localparam longint GATE_MAX = longint'(LONG_GATE_S) * SECOND_LEN + 2;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // decoded override conditions
    wire logic tst = switch_bank_a[TEST_ENABLE_BIT];
    wire logic f1 = tst & switch_bank_a[FORCE_ONES_BIT];
    wire logic f0 = tst & switch_bank_a[FORCE_ZEROS_BIT] & !f1;
    wire logic lt = tst & switch_bank_a[LAMP_TEST_BIT];
    // rate decode, spare codes fall to the slowest rate
    wire logic [2:0] rc = switch_bank_b[RATE_LSB+2:RATE_LSB];
    wire logic [31:0] want_cyc =
        (rc == RATE_600) ? BIT_CYCLES_600 :
        (rc == RATE_1200) ? BIT_CYCLES_1200 :
        (rc == RATE_2400) ? BIT_CYCLES_2400 :
        (rc == RATE_4800) ? BIT_CYCLES_4800 :
        (rc == RATE_9600) ? BIT_CYCLES_9600 : BIT_CYCLES_300;
    // cycles since the last gate end; wide so the long gate fits
    logic [47:0] since_done;
    always_ff @(posedge aclk) begin
        if (!aresetn || gate_done) since_done <= '0;
        else since_done <= since_done + 48'h1;
    end
    a_force_ones: assert property (f1 |=> trim_code == '1)
        else $error("trim not all ones under force");
    a_force_zeros: assert property (f0 |=> trim_code == '0)
        else $error("trim not all zeros under force");
    a_lamp_test: assert property (lt |=> alarm_lamp == '1)
        else $error("lamps not all lit in lamp test");
    a_lamp_follow: assert property
        (!lt |=> alarm_lamp == $past(alarm_state))
        else $error("lamps do not follow alarms");
    a_offset_sign: assert property
        (1'h1 |=> offset_positive == $past(switch_bank_a[OFFSET_SIGN_BIT]))
        else $error("offset sign wrong");
    a_offset_chan: assert property (1'h1 |=>
        offset_channel == $past(switch_bank_b[4:1])
        && offset_enable == (|$past(switch_bank_b[4:1])))
        else $error("offset channel wrong");
    a_rate_map: assert property
        (1'h1 |=> bit_cycles == $past(want_cyc))
        else $error("bit period wrong for rate code");
    a_gate_pulse: assert property (gate_done |=> !gate_done [*8])
        else $error("gate end pulse too long");
    a_gate_bound: assert property
        (since_done <= 48'(GATE_MAX))
        else $error("gate longer than the long gate");
endmodule : trim_monitor

bind oscillator_trim_strap_decode trim_monitor #(
    .TRIM_WIDTH(TRIM_WIDTH), .ALARM_COUNT(ALARM_COUNT),
    .SECOND_LEN(SECOND_LEN)
) trim_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .switch_bank_a(switch_bank_a),
    .switch_bank_b(switch_bank_b), .alarm_state(alarm_state),
    .trim_code(trim_code), .alarm_lamp(alarm_lamp),
    .gate_done(gate_done), .bit_cycles(bit_cycles),
    .offset_positive(offset_positive), .offset_channel(offset_channel),
    .offset_enable(offset_enable)
);

// ===== verif/switch_model.sv
`timescale 1ns/1ps
module switch_model
    import osc_trim_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic load, // move switches to request
    input wire logic [7:0] req_a, // requested bank a
    input wire logic [7:0] req_b, // requested bank b
    input wire logic [15:0] trim_code, // converter input
    output logic [7:0] switch_bank_a, // bank a levels
    output logic [7:0] switch_bank_b, // bank b levels
    output logic [15:0] dac_code // code held by converter
);
    // factory: auto tune on, upper two rate switches on, rest off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switch_bank_a <= BANK_A_RESET;
            switch_bank_b <= BANK_B_RESET;
        end else if (load) begin
            switch_bank_a <= req_a;
            switch_bank_b <= req_b;
        end
    end
    // converter latches the code every cycle
    always_ff @(posedge aclk) dac_code <= trim_code;
endmodule : switch_model

// ===== verif/oscillator_trim_strap_decode_tb.sv
`timescale 1ns/1ps
module oscillator_trim_strap_decode_tb;
    import osc_trim_pkg::*;
    localparam int SL = 10; // short second keeps gates brief
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic load = 1'h0;
    logic [7:0] req_a = 8'h00, req_b = 8'h00, sw_a, sw_b;
    logic [1:0] alarm_state = 2'h0, alarm_lamp, bresp, rresp, rs;
    logic fev = 1'h0, feh = 1'h0, tev = 1'h0, tel = 1'h0;
    logic [15:0] trim_code, dac_code, mt;
    logic gate_active, gate_done, offset_positive, offset_enable;
    logic [31:0] bit_cycles, rdata, rd, seed = 32'h20, wdata = 32'h0;
    logic [3:0] offset_channel;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    int err_count = 0, samples_checked = 0, i, n, c;
    int baud[8] = '{300, 9600, 4800, 2400, 1200, 600, 300, 300};
    logic [7:0] ov[4] = '{8'h22, 8'h24, 8'h26, 8'h30};
    always #5 aclk = ~aclk;
    oscillator_trim_strap_decode #(.SECOND_LEN(SL))
        oscillator_trim_strap_decode_i (
        .aclk(aclk), .aresetn(aresetn), .switch_bank_a(sw_a),
        .switch_bank_b(sw_b), .alarm_state(alarm_state),
        .freq_error_valid(fev), .freq_error_high(feh),
        .time_error_valid(tev), .time_error_late(tel),
        .trim_code(trim_code), .alarm_lamp(alarm_lamp),
        .gate_active(gate_active), .gate_done(gate_done),
        .bit_cycles(bit_cycles), .offset_positive(offset_positive),
        .offset_channel(offset_channel), .offset_enable(offset_enable),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    switch_model switch_model_i (.aclk(aclk), .aresetn(aresetn),
        .load(load), .req_a(req_a), .req_b(req_b), .trim_code(trim_code),
        .switch_bank_a(sw_a), .switch_bank_b(sw_b), .dac_code(dac_code));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // partner takes the request at one edge, design one edge later
    task set_sw(input logic [7:0] a, b);
        req_a <= a;
        req_b <= b;
        load <= 1'h1;
        @(posedge aclk);
        load <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask : set_sw
    task axw(input logic [7:0] ad, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // no local limit: only the watchdog ends a hung wait
        while (!bvalid) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        rs = bresp;
        bready <= 1'h0;
    endtask : axw
    task axr(input logic [7:0] ad);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!rvalid) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask : axr
    // sync to one gate end, then count cycles to the next
    task gate_len;
        for (n = 0; n < 30000 && !gate_done; n++) @(posedge aclk);
        @(posedge aclk);
        for (c = 1; c < 30000 && !gate_done; c++) @(posedge aclk);
    endtask : gate_len
    // a frequency sample, then the trim after the gate closes
    task tune_gate;
        fev <= 1'h1;
        feh <= 1'h1;
        @(posedge aclk);
        fev <= 1'h0;
        gate_len;
        repeat (3) @(posedge aclk);
        check("tuned trim", dac_code, mt);
    endtask : tune_gate
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        check("factory rate", bit_cycles, 32'(CLK_HZ / 300));
        check("gate active", gate_active, 1'h1);
        axr(SWITCH_BANK_B_OFFSET);
        check("bank b", rd, 32'(BANK_B_RESET));
        axr(8'h18);
        check("unmapped rd", {rd[29:0], rs}, {30'h0, RESP_SLVERR});
        axw(8'h1C, 32'h1);
        check("unmapped wr", rs, RESP_SLVERR);
        for (i = 0; i < 8; i++) begin
            set_sw(8'h00, 8'(i << 5));
            check("bit cycles", bit_cycles, 32'(CLK_HZ / baud[i]));
        end
        $display("rate test done");
        // overrides set at random but test enable off
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            alarm_state <= seed[9:8];
            set_sw(seed[7:0] & 8'h1F, seed[15:8]);
            check("sign", offset_positive, seed[0]);
            check("channel", offset_channel, seed[12:9]);
            check("offset on", offset_enable, |seed[12:9]);
            check("lamps", alarm_lamp, seed[9:8]);
            check("trim held", dac_code, TRIM_RESET);
        end
        $display("offset test done");
        alarm_state <= 2'h0;
        for (i = 0; i < 4; i++) begin
            set_sw(ov[i], 8'hC0);
            mt = TRIM_RESET;
            if (ov[i][1]) mt = 16'hFFFF;
            else if (ov[i][2]) mt = 16'h0000;
            check("forced trim", dac_code, mt);
            check("lamp test", alarm_lamp, {2{ov[i][4]}});
        end
        // lamp test alone: override flag up, no force, trim untouched
        axr(TRIM_STATUS_OFFSET);
        check("status", rd, {12'h000, 4'h8, TRIM_RESET});
        $display("override test done");
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axw(TRIM_CTRL_OFFSET, 32'h2);
        check("ctrl wr", rs, RESP_OKAY);
        mt = TRIM_RESET + 16'h2;
        tune_gate;
        set_sw(8'h80, 8'hC0);
        tev <= 1'h1;
        tel <= 1'h1;
        @(posedge aclk);
        tev <= 1'h0;
        mt = mt - 16'h2;
        repeat (3) @(posedge aclk);
        check("phase slew", dac_code, mt);
        set_sw(8'h00, 8'hC0);
        tune_gate;
        $display("tuning test done");
        set_sw(8'h28, 8'hC0);
        gate_len;
        check("short gate", c, SHORT_GATE_S * SL);
        set_sw(8'h08, 8'hC0);
        gate_len;
        check("long gate", c, LONG_GATE_S * SL);
        $display("gate test done");
        give_verdict;
    end
    // the tests need about 61000 cycles, mostly long gates
    initial begin
        repeat (90000) @(posedge aclk);
        err_count++;
        give_verdict;
    end
endmodule : oscillator_trim_strap_decode_tb
